// file: include/gpp_pkg.sv
// package for the gpio port: register map, reset values and widths
package gpp_pkg;

   // ==========================================================
   // port geometry
   // ==========================================================
   localparam int          PORT_W      = 8;   // pins in this port
   localparam int          ADDR_W      = 12;  // apb address bits decoded
   localparam int          BLOCK_PITCH = 32'h0000_0040; // spacing of port blocks from gpio base
   localparam logic [2:0]  USB_PIN     = 3'h6; // pin index that is the usb pull-up pin

   // ==========================================================
   // register offsets within one port block
   // ==========================================================
   localparam logic [5:0] OFS_BYPASS     = 6'h00;
   localparam logic [5:0] OFS_DIRECTION  = 6'h04;
   localparam logic [5:0] OFS_DRIVE_EN   = 6'h08;
   localparam logic [5:0] OFS_DRIVE_LVL  = 6'h0C;
   localparam logic [5:0] OFS_PIN_LEVEL  = 6'h10;
   localparam logic [5:0] OFS_BLOCK      = 6'h14;
   localparam logic [5:0] OFS_UNBLOCK_WR = 6'h18;
   localparam logic [5:0] OFS_BLOCK_WR   = 6'h1C;
   localparam logic [5:0] OFS_FLAGS      = 6'h20;
   localparam logic [5:0] OFS_KIND       = 6'h24;
   localparam logic [5:0] OFS_POLARITY   = 6'h28;
   localparam logic [5:0] OFS_BOTH_EDGES = 6'h2C;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [7:0] RST_BYPASS    = 8'h40;  // usb pull-up pin starts bypassed
   localparam logic [7:0] RST_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_DRIVE_EN  = 8'h00;
   localparam logic [7:0] RST_DRIVE_LVL = 8'h00;
   localparam logic [7:0] RST_BLOCK     = 8'hFF;
   localparam logic [7:0] RST_FLAGS     = 8'h00;
   localparam logic [7:0] RST_KIND      = 8'h00;
   localparam logic [7:0] RST_POLARITY  = 8'h00;
   localparam logic [7:0] RST_BOTH      = 8'h00;

   typedef logic [PORT_W-1:0] gpp_pins_t;

endpackage : gpp_pkg

// file: src/gpp_port.sv
// one gpio port: pin muxing, bypass, event detection, apb registers
//
// Functional notes
// RULE1: bypass bit 1 hands pin output, enable and direction to peripheral.
// RULE2: bypass paths are combinational, never latched or registered.
// RULE3: bypassed pin ignores gpio direction and drive enable settings.
// RULE4: direction 1 is input, 0 is output; resets to all ones.
// RULE5: drive enable gates output buffer only in gpio output mode.
// RULE6: in gpio input mode active-low pad enable stays at 1.
// RULE7: output value reaches pad only in gpio output mode.
// RULE8: input value register reads current pin levels in any mode.
// RULE9: block bit 1 excludes event from interrupt; read-only, resets ones.
// RULE10: unblock write clears block bits written with one.
// RULE11: block write sets block bits written with one.
// RULE12: events set flags regardless of block; reading flags clears all.
// RULE13: trigger kind 1 is level-sensitive, 0 edge-sensitive.
// RULE14: polarity 1 is high or rising, 0 low or falling.
// RULE15: both-edges bit makes any edge an event; ignored for level.
// RULE16: one level interrupt, OR of unblocked flags.
// RULE17: one bit per pin at low positions, rest reserved.
// RULE18: port blocks sit 0x40 apart from gpio base.
// RULE19: after power-on reset pins are gpio inputs, all events blocked.
// RULE20: usb pull-up pin leaves power-on reset in bypass mode.
// RULE21: state kept through power-down, reset only by power-on reset.
// RULE22: software should disable output and block event before mode change.
// RULE23: pin inputs synchronised; edges from successive synchronised samples.
// RULE24: reserved bits read zero, writes to them ignored.
`timescale 1ns/1ps
`default_nettype none

module gpp_port
   import gpp_pkg::*;
#(
   parameter logic [ADDR_W-1:0] PORT_BASE = 12'h000 // this port's block offset
)
(
   input  wire logic              CLOCK_I,
   input  wire logic              RST_N_I,
   // apb slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output var  logic [31:0]       PRDATA_O,
   output var  logic              PREADY_O,
   output var  logic              PSLVERR_O,
   // pads
   input  wire logic [PORT_W-1:0] PIN_IN_I,
   output logic      [PORT_W-1:0] PIN_OUT_O,
   output logic      [PORT_W-1:0] PIN_OE_N_O,
   // peripheral side for bypass
   input  wire logic [PORT_W-1:0] PERIPH_OUT_I,
   input  wire logic [PORT_W-1:0] PERIPH_OE_N_I,
   output logic      [PORT_W-1:0] PERIPH_IN_O,
   // port interrupt
   output var  logic              PORT_IRQ_O
);

   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      gpp_pins_t   bypass;
      gpp_pins_t   direction;
      gpp_pins_t   drive_en;
      gpp_pins_t   drive_lvl;
      gpp_pins_t   block;
      gpp_pins_t   flags;
      gpp_pins_t   kind;
      gpp_pins_t   polarity;
      gpp_pins_t   both;
      gpp_pins_t   sync1;
      gpp_pins_t   sync2;
      gpp_pins_t   sync3;
      gpp_pins_t   level;       // agreed pin level
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        irq;
      gpp_pins_t   gpio_out;
      gpp_pins_t   gpio_oe_n;
   } gpp_state_t;

   gpp_state_t st;
   gpp_state_t next_st;

   // ==========================================================
   // helpers
   // ==========================================================
   // pin-wise merge of a written byte: set bits where mask
   function automatic gpp_pins_t merge_set(input gpp_pins_t cur, input gpp_pins_t msk);
      merge_set = cur | msk;
   endfunction : merge_set

   // widen a pin vector onto the 32-bit read bus, upper bits zero
   function automatic logic [31:0] widen(input gpp_pins_t v);
      widen = {{(32-PORT_W){1'b0}}, v};
   endfunction : widen

   // an offset is mapped when it is word aligned and not above OFS_BOTH_EDGES
   function automatic logic ofs_mapped(input logic [5:0] o);
      ofs_mapped = (o <= OFS_BOTH_EDGES) && (o[1:0] == 2'b00);
   endfunction : ofs_mapped

   // ==========================================================
   // pad and peripheral muxing
   // ==========================================================
   // a bypassed pin passes straight through with no flop, so the owning
   // peripheral keeps its own timing; gpio pins use the registered values
   // RULE1 bypass hands pin over
   // RULE2 combinational bypass path
   // RULE3 peripheral owns direction
   always_comb
   begin
      for (int i = 0; i < PORT_W; i++)
      begin
         if (st.bypass[i])
         begin
            PIN_OUT_O[i]  = PERIPH_OUT_I[i];
            PIN_OE_N_O[i] = PERIPH_OE_N_I[i];
         end
         else
         begin
            PIN_OUT_O[i]  = st.gpio_out[i];
            PIN_OE_N_O[i] = st.gpio_oe_n[i];
         end
      end
   end

   assign PERIPH_IN_O = PIN_IN_I;     // peripheral sees raw pad input

   // every transfer is answered in its access phase with no wait state;
   // a write lands at the setup edge, one cycle before ready is seen
   // apb answers
   assign PRDATA_O   = st.rdata;
   assign PREADY_O   = st.ready;
   assign PSLVERR_O  = st.slverr;
   assign PORT_IRQ_O = st.irq;

   // ==========================================================
   // next-state logic
   // ==========================================================
   // helper nets filled by the next-state process
   logic        setup;
   logic        hit;
   logic [5:0]  ofs;
   gpp_pins_t   wbyte;
   gpp_pins_t   event_now;
   gpp_pins_t   rise;
   gpp_pins_t   fall;

   always_comb
   begin
      next_st = st;
      // only the upper address bits pick the port block, so each port
      // instance serves just its own window of registers and refuses any other address with an error
      // RULE18 block decode
      hit   = (PADDR_I[ADDR_W-1:6] == PORT_BASE[ADDR_W-1:6]);
      ofs   = PADDR_I[5:0];
      // RULE24 reserved bits dropped
      wbyte = PWDATA_I[PORT_W-1:0];
      setup = PSEL_I && !PENABLE_I;

      // the first stage may go metastable, so only the second and third
      // stages are compared; a level that has not held for two samples
      // is treated as noise and the agreed level keeps its old value
      // RULE23 three-stage synchroniser, change once stages agree
      next_st.sync1 = PIN_IN_I;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int i = 0; i < PORT_W; i++)
      begin
         if (st.sync2[i] == st.sync3[i])
         begin
            next_st.level[i] = st.sync3[i];
         end
      end

      // RULE23 edges from successive samples
      rise = next_st.level & ~st.level;
      fall = ~next_st.level & st.level;
      for (int i = 0; i < PORT_W; i++)
      begin
         // RULE13 level or edge
         if (st.kind[i])
         begin
            // RULE14 high or low level
            event_now[i] = (next_st.level[i] == st.polarity[i]);
         end
         // RULE15 any edge overrides
         else if (st.both[i])
         begin
            event_now[i] = rise[i] | fall[i];
         end
         else
         begin
            // RULE14 rising or falling
            event_now[i] = st.polarity[i] ? rise[i] : fall[i];
         end
      end

      // answer one cycle after setup, access phase sees ready
      next_st.ready  = setup;
      next_st.slverr = 1'b0;
      next_st.rdata  = 32'h0000_0000;

      // a read clear and a fresh event in one cycle must not lose the
      // event, so the events of that cycle are loaded instead of zero
      // RULE12 flags set regardless of block, set wins over read clear
      if (setup && !PWRITE_I && hit && ofs == OFS_FLAGS)
      begin
         next_st.flags = event_now;
      end
      else
      begin
         next_st.flags = merge_set(st.flags, event_now);
      end

      if (setup)
      begin
         if (!hit || !ofs_mapped(ofs))
         begin
            next_st.slverr = 1'b1;        // unmapped address
         end
         else if (PWRITE_I)
         begin
            // read-only offsets fall through, writes there change nothing
            if (ofs == OFS_BYPASS)
            begin
               next_st.bypass = wbyte;
            end
            else if (ofs == OFS_DIRECTION)
            begin
               next_st.direction = wbyte;
            end
            else if (ofs == OFS_DRIVE_EN)
            begin
               next_st.drive_en = wbyte;
            end
            else if (ofs == OFS_DRIVE_LVL)
            begin
               next_st.drive_lvl = wbyte;
            end
            else if (ofs == OFS_UNBLOCK_WR)
            begin
               // RULE10 clear written ones
               next_st.block = st.block & ~wbyte;
            end
            else if (ofs == OFS_BLOCK_WR)
            begin
               // RULE11 set written ones
               next_st.block = merge_set(st.block, wbyte);
            end
            else if (ofs == OFS_KIND)
            begin
               next_st.kind = wbyte;
            end
            else if (ofs == OFS_POLARITY)
            begin
               next_st.polarity = wbyte;
            end
            else if (ofs == OFS_BOTH_EDGES)
            begin
               next_st.both = wbyte;
            end
         end
         else
         begin
            // write-only offsets fall through and read back as zero
            // RULE17 pins in low bits
            if (ofs == OFS_BYPASS)
            begin
               next_st.rdata = widen(st.bypass);
            end
            else if (ofs == OFS_DIRECTION)
            begin
               next_st.rdata = widen(st.direction);
            end
            else if (ofs == OFS_DRIVE_EN)
            begin
               next_st.rdata = widen(st.drive_en);
            end
            else if (ofs == OFS_DRIVE_LVL)
            begin
               next_st.rdata = widen(st.drive_lvl);
            end
            else if (ofs == OFS_PIN_LEVEL)
            begin
               // RULE8 level in any mode
               next_st.rdata = widen(st.level);
            end
            else if (ofs == OFS_BLOCK)
            begin
               // RULE9 block reads back
               next_st.rdata = widen(st.block);
            end
            else if (ofs == OFS_FLAGS)
            begin
               next_st.rdata = widen(st.flags);
            end
            else if (ofs == OFS_KIND)
            begin
               next_st.rdata = widen(st.kind);
            end
            else if (ofs == OFS_POLARITY)
            begin
               next_st.rdata = widen(st.polarity);
            end
            else if (ofs == OFS_BOTH_EDGES)
            begin
               next_st.rdata = widen(st.both);
            end
         end
      end

      // RULE4 direction selects output
      // RULE5 drive enable only in output
      // RULE6 input keeps buffer off
      // RULE7 value only when output
      for (int i = 0; i < PORT_W; i++)
      begin
         if (next_st.direction[i])
         begin
            next_st.gpio_oe_n[i] = 1'b1;
            next_st.gpio_out[i]  = 1'b0;
         end
         else
         begin
            next_st.gpio_oe_n[i] = ~next_st.drive_en[i];
            next_st.gpio_out[i]  = next_st.drive_lvl[i];
         end
      end

      // the line is built from the next flags and block so that it moves
      // on the same edge as the status it summarises, with no extra lag
      // RULE16 or of unblocked flags
      // RULE9 block excludes pin
      next_st.irq = |(next_st.flags & ~next_st.block);
   end

   // ==========================================================
   // registers
   // ==========================================================
   // the synchroniser and agreed level start low; with the reset trigger
   // on falling edges a pin that idles high gives no false event
   // RULE19 inputs and all blocked at reset
   // RULE20 usb pin bypassed at reset
   // RULE21 only power-on reset clears state
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         st           <= '0;
         st.bypass    <= RST_BYPASS;
         st.direction <= RST_DIRECTION;
         st.drive_en  <= RST_DRIVE_EN;
         st.drive_lvl <= RST_DRIVE_LVL;
         st.block     <= RST_BLOCK;
         st.flags     <= RST_FLAGS;
         st.kind      <= RST_KIND;
         st.polarity  <= RST_POLARITY;
         st.both      <= RST_BOTH;
         st.gpio_oe_n <= '1;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule : gpp_port

`default_nettype wire

// file: test/gpp_pads.sv
// pad model: outside drivers and the port meeting on each pin
`timescale 1ns/1ps
`default_nettype none
module gpp_pads
(
   input  wire logic [7:0] ext_i,
   input  wire logic [7:0] out_i,
   input  wire logic [7:0] oe_n_i,
   output logic      [7:0] pin_o
);
   // ==========================================================
   // pad level
   // ==========================================================
   // port wins where its buffer is on, the outside level elsewhere
   assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : gpp_pads
`default_nettype wire

// file: test/gpp_port_monitor.sv
// assertions on the gpio port pins and apb answers
`timescale 1ns/1ps
`default_nettype none
module gpp_port_monitor
   import gpp_pkg::*;
#(
   parameter logic [ADDR_W-1:0] PORT_BASE = 12'h000
)
(
   input wire logic              CLOCK_I,
   input wire logic              RST_N_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PWDATA_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic [PORT_W-1:0] PIN_IN_I,
   input wire logic [PORT_W-1:0] PIN_OUT_O,
   input wire logic [PORT_W-1:0] PIN_OE_N_O,
   input wire logic [PORT_W-1:0] PERIPH_OUT_I,
   input wire logic [PORT_W-1:0] PERIPH_OE_N_I,
   input wire logic [PORT_W-1:0] PERIPH_IN_O,
   input wire logic              PORT_IRQ_O
);
   // ==========================================================
   // shadow of bypass, direction and block bits
   // ==========================================================
   logic [7:0] byp;
   logic [7:0] dir;
   logic [7:0] blk;
   logic       wr_s;
   logic       setup;
   assign setup = PSEL_I && !PENABLE_I;
   assign wr_s  = setup && PWRITE_I && (PADDR_I[11:6] == PORT_BASE[11:6]);
   // writes land at the setup edge
   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         byp <= RST_BYPASS;
         dir <= RST_DIRECTION;
         blk <= RST_BLOCK;
      end
      else if (wr_s)
      begin
         if (PADDR_I[5:0] == OFS_BYPASS)
            byp <= PWDATA_I[7:0];
         if (PADDR_I[5:0] == OFS_DIRECTION)
            dir <= PWDATA_I[7:0];
         if (PADDR_I[5:0] == OFS_UNBLOCK_WR)
            blk <= blk & ~PWDATA_I[7:0];
         if (PADDR_I[5:0] == OFS_BLOCK_WR)
            blk <= blk | PWDATA_I[7:0];
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // ==========================================================
   // checks
   // ==========================================================
   bypass_out_a: assert property ((PIN_OUT_O & byp) == (PERIPH_OUT_I & byp))
      else $error("bypassed pin value differs from peripheral");
   bypass_dir_a: assert property ((PIN_OE_N_O & byp) == (PERIPH_OE_N_I & byp))
      else $error("bypassed pin enable differs from peripheral");
   input_off_a: assert property (((dir & $past(dir) & ~byp & ~$past(byp)) & ~PIN_OE_N_O) == 8'h00)
      else $error("input pin has its driver on");
   periph_in_a: assert property (PERIPH_IN_O == PIN_IN_I)
      else $error("peripheral input differs from pin");
   reserved_zero_a: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h00_0000)
      else $error("reserved read bits not zero");
   other_block_a: assert property (setup && (PADDR_I[11:6] != PORT_BASE[11:6]
      || PADDR_I[5:0] > OFS_BOTH_EDGES) |=> PREADY_O && PSLVERR_O)
      else $error("foreign address not refused");
   masked_quiet_a: assert property ((&blk && &$past(blk)) |-> !PORT_IRQ_O)
      else $error("interrupt with all events blocked");
   reset_state_a: assert property ($rose(RST_N_I) |-> PIN_OE_N_O[5:0] == 6'h3F && PIN_OE_N_O[7]
      && PIN_OUT_O[6] == PERIPH_OUT_I[6] && !PORT_IRQ_O)
      else $error("pins not in reset state");
   cover property (PORT_IRQ_O);
   cover property (PSLVERR_O);
   cover property (PREADY_O && PRDATA_O[7:0] != 8'h00);
endmodule : gpp_port_monitor
`default_nettype wire

// file: test/gpp_port_test.sv
// self-checking bench for one gpio port
`timescale 1ns/1ps
`default_nettype none
module gpp_port_test import gpp_pkg::*;;
   typedef struct packed {logic w; logic [5:0] wa; logic [7:0] wd; logic [5:0] ra; logic [7:0] ex;} gpp_row_t;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  pin_in, pin_out, pin_oe_n, per_out, per_oe_n, per_in, ext;
   int          errors, checked;
   gpp_row_t    rows [24] = '{
      '{1'b0, 6'h00, 8'h00, 6'h00, 8'h40}, '{1'b0, 6'h00, 8'h00, 6'h04, 8'hFF},
      '{1'b0, 6'h00, 8'h00, 6'h08, 8'h00}, '{1'b0, 6'h00, 8'h00, 6'h0C, 8'h00},
      '{1'b0, 6'h00, 8'h00, 6'h14, 8'hFF}, '{1'b0, 6'h00, 8'h00, 6'h18, 8'h00},
      '{1'b0, 6'h00, 8'h00, 6'h1C, 8'h00}, '{1'b0, 6'h00, 8'h00, 6'h20, 8'h00},
      '{1'b0, 6'h00, 8'h00, 6'h24, 8'h00}, '{1'b0, 6'h00, 8'h00, 6'h28, 8'h00},
      '{1'b0, 6'h00, 8'h00, 6'h2C, 8'h00}, '{1'b0, 6'h00, 8'h00, 6'h10, 8'h3C},
      '{1'b1, 6'h10, 8'hFF, 6'h10, 8'h3C}, '{1'b1, 6'h14, 8'h00, 6'h14, 8'hFF},
      '{1'b1, 6'h18, 8'h0F, 6'h14, 8'hF0}, '{1'b1, 6'h1C, 8'h03, 6'h14, 8'hF3},
      '{1'b1, 6'h1C, 8'hFF, 6'h14, 8'hFF}, '{1'b1, 6'h00, 8'h00, 6'h00, 8'h00},
      '{1'b1, 6'h04, 8'h5A, 6'h04, 8'h5A}, '{1'b1, 6'h08, 8'hA5, 6'h08, 8'hA5},
      '{1'b1, 6'h0C, 8'hC3, 6'h0C, 8'hC3}, '{1'b1, 6'h24, 8'h96, 6'h24, 8'h96},
      '{1'b1, 6'h28, 8'h69, 6'h28, 8'h69}, '{1'b1, 6'h2C, 8'h3C, 6'h2C, 8'h3C}};
   gpp_port uut
   (
      .CLOCK_I(clock), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n), .PERIPH_OUT_I(per_out),
      .PERIPH_OE_N_I(per_oe_n), .PERIPH_IN_O(per_in), .PORT_IRQ_O(irq)
   );
   gpp_pads pads (.ext_i(ext), .out_i(pin_out), .oe_n_i(pin_oe_n), .pin_o(pin_in));
   // ==========================================================
   // report and compare
   // ==========================================================
   task automatic finish_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk32({24'h00_0000, got}, {24'h00_0000, exp});
   endtask : chk8
   // ==========================================================
   // apb master: holds the request until pready is seen
   // ==========================================================
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'hFF_FFFF, d};
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++)
         @(posedge clock);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         errors++;
         finish_test();
      end
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk32(rd, {24'h00_0000, e});
      chk8({7'h00, err}, 8'h00);
   endtask : rchk
   // clock of 25 ns
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // main sequence
   initial
   begin
      {errors, checked} = '0;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      ext      = 8'h3C;
      per_out  = 8'h40;
      per_oe_n = 8'hFF;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1 chk8(pin_out, 8'h40);
      chk8(pin_oe_n, 8'hFF);
      foreach (rows[i])
      begin
         if (rows[i].w)
            apb(1'b1, {6'h00, rows[i].wa}, rows[i].wd);
         rchk({6'h00, rows[i].ra}, rows[i].ex);
      end
      $display("test registers done");
      chk8(pin_oe_n, 8'h5A);
      chk8(pin_out, 8'h81);
      apb(1'b1, 12'h004, 8'h0F);
      repeat (2) @(posedge clock);
      chk8(pin_oe_n, 8'h5F);
      chk8(pin_out, 8'hC0);
      rchk(12'h010, 8'h9C);
      apb(1'b1, 12'h000, 8'hFF);
      @(posedge clock);
      per_out  <= 8'h96;
      per_oe_n <= 8'h0F;
      #1 chk8(pin_out, 8'h96);
      chk8(pin_oe_n, 8'h0F);
      chk8(per_in, 8'h9C);
      rchk(12'h010, 8'h9C);
      per_oe_n <= 8'hFF;
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h004, 8'hFF);
      apb(1'b1, 12'h000, 8'h00);
      $display("test pads done");
      apb(1'b1, 12'h024, 8'h03);
      apb(1'b1, 12'h028, 8'h05);
      apb(1'b1, 12'h02C, 8'h11);
      ext <= 8'h00;
      repeat (8) @(posedge clock);
      apb(1'b0, 12'h020, 8'h00);
      repeat (8) @(posedge clock);
      rchk(12'h020, 8'h02);
      ext <= 8'hFF;
      repeat (8) @(posedge clock);
      rchk(12'h020, 8'h17);
      repeat (8) @(posedge clock);
      rchk(12'h020, 8'h01);
      ext <= 8'h00;
      repeat (8) @(posedge clock);
      chk8({7'h00, irq}, 8'h00);
      apb(1'b1, 12'h018, 8'h08);
      repeat (2) @(posedge clock);
      chk8({7'h00, irq}, 8'h01);
      rchk(12'h020, 8'hFB);
      repeat (3) @(posedge clock);
      chk8({7'h00, irq}, 8'h00);
      $display("test events done");
      apb(1'b1, 12'h040, 8'hFF);
      chk8({7'h00, err}, 8'h01);
      apb(1'b0, 12'h030, 8'h00);
      chk8({7'h00, err}, 8'h01);
      apb(1'b0, 12'h002, 8'h00);
      chk8({7'h00, err}, 8'h01);
      rchk(12'h000, 8'h00);
      $display("test address done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rchk(12'h000, 8'h40);
      rchk(12'h014, 8'hFF);
      $display("test reset done");
      finish_test();
   end
endmodule : gpp_port_test
bind gpp_port gpp_port_monitor #(.PORT_BASE(PORT_BASE)) mon
(
   .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_N_O(PIN_OE_N_O), .PERIPH_OUT_I(PERIPH_OUT_I),
   .PERIPH_OE_N_I(PERIPH_OE_N_I), .PERIPH_IN_O(PERIPH_IN_O), .PORT_IRQ_O(PORT_IRQ_O)
);
`default_nettype wire
